// >>> logic/scp_pkg.sv
/*
  Constants and carrier types for the sensor parameter bank.
  Assumes a command engine on the same clock issues parameter read and write strobes.
*/
// Function
// - Bus address held, applied on address command
// - List bit 6 enables auxiliary channel
// - List bit 5 enables ambient infrared
// - List bit 4 enables ambient visible
// - List bits 2:0 enable proximity, reset zero
// - Bits 6:4 select drivers for proximity two
// - Bits 2:0 select drivers for proximity one
// - Second select bits 2:0 for proximity three
// - Proximity align bits pick low or high
// - Ambient align bits pick low or high
// - Parameters reached only through commands
package scp_pkg;

  // ==========================================================================
  // Parameter offsets
  localparam logic [7:0] OFS_BUS_ADDR   = 8'h00;
  localparam logic [7:0] OFS_CHAN_LIST  = 8'h01;
  localparam logic [7:0] OFS_LED_ONE_TWO = 8'h02;
  localparam logic [7:0] OFS_LED_THREE  = 8'h03;
  localparam logic [7:0] OFS_PROX_ALIGN = 8'h05;
  localparam logic [7:0] OFS_AMB_ALIGN  = 8'h06;

  // ==========================================================================
  // Reset values and writable-bit masks
  localparam logic [7:0] RST_BUS_ADDR   = 8'h00;
  localparam logic [7:0] RST_CHAN_LIST  = 8'h00;
  localparam logic [7:0] RST_LED_ONE_TWO = 8'h21;
  localparam logic [7:0] RST_LED_THREE  = 8'h04;
  localparam logic [7:0] RST_PROX_ALIGN = 8'h00;
  localparam logic [7:0] RST_AMB_ALIGN  = 8'h00;
  localparam logic [7:0] MSK_BUS_ADDR   = 8'hff;
  localparam logic [7:0] MSK_CHAN_LIST  = 8'h77;
  localparam logic [7:0] MSK_LED_ONE_TWO = 8'h77;
  localparam logic [7:0] MSK_LED_THREE  = 8'h07;
  localparam logic [7:0] MSK_PROX_ALIGN = 8'h70;
  localparam logic [7:0] MSK_AMB_ALIGN  = 8'h30;

  // ==========================================================================
  // Field positions
  localparam int POS_PROX_ONE_EN  = 0;
  localparam int POS_PROX_TWO_EN  = 1;
  localparam int POS_PROX_THREE_EN = 2;
  localparam int POS_AMB_VIS_EN   = 4;
  localparam int POS_AMB_IR_EN    = 5;
  localparam int POS_AUX_EN       = 6;
  localparam int POS_MASK_LO      = 0;
  localparam int POS_MASK_HI      = 4;
  localparam int POS_PROX_ONE_AL  = 4;
  localparam int POS_PROX_TWO_AL  = 5;
  localparam int POS_PROX_THREE_AL = 6;
  localparam int POS_AMB_VIS_AL   = 4;
  localparam int POS_AMB_IR_AL    = 5;

  // ==========================================================================
  // Decoded configuration carried to the measurement sequencer
  typedef struct packed {
    logic       aux_enable;
    logic       ambient_infrared_enable;
    logic       ambient_visible_enable;
    logic       prox_three_enable;
    logic       prox_two_enable;
    logic       prox_one_enable;
    logic [2:0] prox_one_driver_mask;
    logic [2:0] prox_two_driver_mask;
    logic [2:0] prox_three_driver_mask;
    logic       prox_one_low_align;
    logic       prox_two_low_align;
    logic       prox_three_low_align;
    logic       ambient_visible_low_align;
    logic       ambient_infrared_low_align;
  } scp_cfg_t;

endpackage

// >>> logic/scp_param_bank.sv
/*
  Parameter bank: six byte-wide parameters reached only through read and write commands.
  Assumes the command engine runs on the same clock and presents one-cycle command strobes.
*/
`timescale 1ns/1ps
module scp_param_bank (
  // Clock and reset
  input  wire logic            clock,
  input  wire logic            resetn,
  // Parameter commands
  input  wire logic            parameter_write_cmd,
  input  wire logic            parameter_read_cmd,
  input  wire logic            apply_bus_address_cmd,
  input  wire logic [7:0]      param_offset,
  input  wire logic [7:0]      param_wdata,
  output logic      [7:0]      param_rdata,
  output logic                 param_rvalid,
  // Configuration out
  output logic      [7:0]      active_bus_address,
  output scp_pkg::scp_cfg_t    cfg
);

  // ==========================================================================
  // Storage
  logic [7:0] bus_address_param_q, bus_address_param_d;
  logic [7:0] channel_enable_list_q, channel_enable_list_d;
  logic [7:0] led_select_prox_one_two_q, led_select_prox_one_two_d;
  logic [7:0] led_select_prox_three_q, led_select_prox_three_d;
  logic [7:0] prox_result_alignment_q, prox_result_alignment_d;
  logic [7:0] ambient_result_alignment_q, ambient_result_alignment_d;
  logic [7:0] active_addr_q, active_addr_d;
  logic [7:0] rdata_q, rdata_d;
  logic       rvalid_q, rvalid_d;
  scp_pkg::scp_cfg_t cfg_q, cfg_d;
  logic [7:0] wr_mask;

  // Only the commands reach the storage; there is no direct address path.
  always_comb begin
    bus_address_param_d        = bus_address_param_q;
    channel_enable_list_d      = channel_enable_list_q;
    led_select_prox_one_two_d  = led_select_prox_one_two_q;
    led_select_prox_three_d    = led_select_prox_three_q;
    prox_result_alignment_d    = prox_result_alignment_q;
    ambient_result_alignment_d = ambient_result_alignment_q;
    wr_mask                    = 8'h00;
    unique case (param_offset)
      scp_pkg::OFS_BUS_ADDR:    wr_mask = scp_pkg::MSK_BUS_ADDR;
      scp_pkg::OFS_CHAN_LIST:   wr_mask = scp_pkg::MSK_CHAN_LIST;
      scp_pkg::OFS_LED_ONE_TWO: wr_mask = scp_pkg::MSK_LED_ONE_TWO;
      scp_pkg::OFS_LED_THREE:   wr_mask = scp_pkg::MSK_LED_THREE;
      scp_pkg::OFS_PROX_ALIGN:  wr_mask = scp_pkg::MSK_PROX_ALIGN;
      scp_pkg::OFS_AMB_ALIGN:   wr_mask = scp_pkg::MSK_AMB_ALIGN;
      default:                  wr_mask = 8'h00;
    endcase
    if (parameter_write_cmd) begin
      unique case (param_offset)
        scp_pkg::OFS_BUS_ADDR:    bus_address_param_d = param_wdata & wr_mask;
        scp_pkg::OFS_CHAN_LIST:   channel_enable_list_d = param_wdata & wr_mask;
        scp_pkg::OFS_LED_ONE_TWO: led_select_prox_one_two_d = param_wdata & wr_mask;
        scp_pkg::OFS_LED_THREE:   led_select_prox_three_d = param_wdata & wr_mask;
        scp_pkg::OFS_PROX_ALIGN:  prox_result_alignment_d = param_wdata & wr_mask;
        scp_pkg::OFS_AMB_ALIGN:   ambient_result_alignment_d = param_wdata & wr_mask;
        default: ;
      endcase
    end
  end

  // The address becomes live only on the apply command, so a half-written
  // address never strands the host mid-transaction.
  always_comb begin
    active_addr_d = apply_bus_address_cmd ? bus_address_param_q : active_addr_q;
  end

  // Read answer one cycle after the query; unmapped offsets answer zero.
  always_comb begin
    rvalid_d = parameter_read_cmd;
    rdata_d  = rdata_q;
    if (parameter_read_cmd) begin
      unique case (param_offset)
        scp_pkg::OFS_BUS_ADDR:    rdata_d = bus_address_param_q;
        scp_pkg::OFS_CHAN_LIST:   rdata_d = channel_enable_list_q;
        scp_pkg::OFS_LED_ONE_TWO: rdata_d = led_select_prox_one_two_q;
        scp_pkg::OFS_LED_THREE:   rdata_d = led_select_prox_three_q;
        scp_pkg::OFS_PROX_ALIGN:  rdata_d = prox_result_alignment_q;
        scp_pkg::OFS_AMB_ALIGN:   rdata_d = ambient_result_alignment_q;
        default:                  rdata_d = 8'h00;
      endcase
    end
  end

  // Decode fields from the next values so cfg tracks the stored bytes in the same edge.
  always_comb begin
    cfg_d.aux_enable                 = channel_enable_list_d[scp_pkg::POS_AUX_EN];
    cfg_d.ambient_infrared_enable    = channel_enable_list_d[scp_pkg::POS_AMB_IR_EN];
    cfg_d.ambient_visible_enable     = channel_enable_list_d[scp_pkg::POS_AMB_VIS_EN];
    cfg_d.prox_three_enable          = channel_enable_list_d[scp_pkg::POS_PROX_THREE_EN];
    cfg_d.prox_two_enable            = channel_enable_list_d[scp_pkg::POS_PROX_TWO_EN];
    cfg_d.prox_one_enable            = channel_enable_list_d[scp_pkg::POS_PROX_ONE_EN];
    cfg_d.prox_one_driver_mask       = led_select_prox_one_two_d[scp_pkg::POS_MASK_LO +: 3];
    cfg_d.prox_two_driver_mask       = led_select_prox_one_two_d[scp_pkg::POS_MASK_HI +: 3];
    cfg_d.prox_three_driver_mask     = led_select_prox_three_d[scp_pkg::POS_MASK_LO +: 3];
    cfg_d.prox_one_low_align         = prox_result_alignment_d[scp_pkg::POS_PROX_ONE_AL];
    cfg_d.prox_two_low_align         = prox_result_alignment_d[scp_pkg::POS_PROX_TWO_AL];
    cfg_d.prox_three_low_align       = prox_result_alignment_d[scp_pkg::POS_PROX_THREE_AL];
    cfg_d.ambient_visible_low_align  = ambient_result_alignment_d[scp_pkg::POS_AMB_VIS_AL];
    cfg_d.ambient_infrared_low_align = ambient_result_alignment_d[scp_pkg::POS_AMB_IR_AL];
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      bus_address_param_q        <= scp_pkg::RST_BUS_ADDR;
      channel_enable_list_q      <= scp_pkg::RST_CHAN_LIST;
      led_select_prox_one_two_q  <= scp_pkg::RST_LED_ONE_TWO;
      led_select_prox_three_q    <= scp_pkg::RST_LED_THREE;
      prox_result_alignment_q    <= scp_pkg::RST_PROX_ALIGN;
      ambient_result_alignment_q <= scp_pkg::RST_AMB_ALIGN;
      active_addr_q              <= scp_pkg::RST_BUS_ADDR;
      rdata_q                    <= 8'h00;
      rvalid_q                   <= 1'b0;
      cfg_q                      <= '{default: 1'b0,
                                      prox_one_driver_mask:   scp_pkg::RST_LED_ONE_TWO[2:0],
                                      prox_two_driver_mask:   scp_pkg::RST_LED_ONE_TWO[6:4],
                                      prox_three_driver_mask: scp_pkg::RST_LED_THREE[2:0]};
    end else begin
      bus_address_param_q        <= bus_address_param_d;
      channel_enable_list_q      <= channel_enable_list_d;
      led_select_prox_one_two_q  <= led_select_prox_one_two_d;
      led_select_prox_three_q    <= led_select_prox_three_d;
      prox_result_alignment_q    <= prox_result_alignment_d;
      ambient_result_alignment_q <= ambient_result_alignment_d;
      active_addr_q              <= active_addr_d;
      rdata_q                    <= rdata_d;
      rvalid_q                   <= rvalid_d;
      cfg_q                      <= cfg_d;
    end
  end

  assign param_rdata        = rdata_q;
  assign param_rvalid       = rvalid_q;
  assign active_bus_address = active_addr_q;
  assign cfg                = cfg_q;

  // ==========================================================================
  // Checks
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);

  sequence s_addr_write;
    parameter_write_cmd && param_offset == scp_pkg::OFS_BUS_ADDR && !apply_bus_address_cmd;
  endsequence

  chk_addr_held_apply: assert property (s_addr_write ##1 !apply_bus_address_cmd |=> $stable(active_bus_address))
    else $error("Bus address changed without apply command.");
  chk_addr_apply_load: assert property (apply_bus_address_cmd |=> active_bus_address == $past(bus_address_param_q))
    else $error("Apply command did not load bus address.");
  chk_aux_enable_bit: assert property (parameter_write_cmd && param_offset == scp_pkg::OFS_CHAN_LIST
      |=> cfg.aux_enable == $past(param_wdata[6]))
    else $error("Auxiliary enable does not follow list bit 6.");
  chk_ir_enable_bit: assert property (cfg.ambient_infrared_enable == channel_enable_list_q[5])
    else $error("Infrared enable mismatch.");
  chk_vis_enable_bit: assert property (cfg.ambient_visible_enable == channel_enable_list_q[4])
    else $error("Visible enable mismatch.");
  chk_prox_enable_bits: assert property ({cfg.prox_three_enable, cfg.prox_two_enable, cfg.prox_one_enable}
      == channel_enable_list_q[2:0])
    else $error("Proximity enables mismatch.");
  chk_led_two_mask: assert property (parameter_write_cmd && param_offset == scp_pkg::OFS_LED_ONE_TWO
      |=> cfg.prox_two_driver_mask == $past(param_wdata[6:4]))
    else $error("Proximity two mask wrong.");
  chk_led_one_mask: assert property (cfg.prox_one_driver_mask == led_select_prox_one_two_q[2:0])
    else $error("Proximity one mask wrong.");
  chk_led_three_rsvd: assert property (led_select_prox_three_q[7:3] == 5'h00)
    else $error("Reserved bits set in third select.");
  chk_prox_align_bits: assert property (
      {cfg.prox_three_low_align, cfg.prox_two_low_align, cfg.prox_one_low_align} == prox_result_alignment_q[6:4])
    else $error("Proximity alignment mismatch.");
  chk_amb_align_bits: assert property ({cfg.ambient_infrared_low_align, cfg.ambient_visible_low_align}
      == ambient_result_alignment_q[5:4])
    else $error("Ambient alignment mismatch.");
  chk_read_answer: assert property (parameter_read_cmd && param_offset == scp_pkg::OFS_PROX_ALIGN
      |=> param_rvalid && param_rdata[3:0] == 4'h0 && param_rdata[7] == 1'b0)
    else $error("Reserved alignment bits read non-zero.");

  // ==========================================================================
  // Checks on commands and stored bytes
  // The mapped-offset decode is kept apart from the write mask, so a wrong mask
  // entry cannot hide itself from the checks below.
  logic offset_mapped;
  assign offset_mapped = param_offset inside {scp_pkg::OFS_BUS_ADDR, scp_pkg::OFS_CHAN_LIST,
                                              scp_pkg::OFS_LED_ONE_TWO, scp_pkg::OFS_LED_THREE,
                                              scp_pkg::OFS_PROX_ALIGN, scp_pkg::OFS_AMB_ALIGN};

  chk_reset_defaults: assert property ($rose(resetn) |-> active_bus_address == scp_pkg::RST_BUS_ADDR
      && {cfg.prox_three_enable, cfg.prox_two_enable, cfg.prox_one_enable} == scp_pkg::RST_CHAN_LIST[2:0]
      && cfg.prox_one_driver_mask == scp_pkg::RST_LED_ONE_TWO[2:0]
      && cfg.prox_two_driver_mask == scp_pkg::RST_LED_ONE_TWO[6:4]
      && cfg.prox_three_driver_mask == scp_pkg::RST_LED_THREE[2:0] && !param_rvalid)
    else $error("Parameter bank left reset with wrong defaults.");
  chk_rvalid_pulse: assert property (param_rvalid == $past(parameter_read_cmd))
    else $error("Read answer strobe not one cycle after the query.");
  chk_unmapped_read: assert property (parameter_read_cmd && !offset_mapped |=> param_rdata == 8'h00)
    else $error("Unmapped offset read non-zero.");
  chk_unmapped_write: assert property (parameter_write_cmd && !offset_mapped |=>
      $stable({bus_address_param_q, channel_enable_list_q, led_select_prox_one_two_q, led_select_prox_three_q,
               prox_result_alignment_q, ambient_result_alignment_q}))
    else $error("Write to unmapped offset changed a parameter.");
  chk_addr_store: assert property (parameter_write_cmd && param_offset == scp_pkg::OFS_BUS_ADDR
      |=> bus_address_param_q == $past(param_wdata))
    else $error("Bus address write not stored.");
  chk_prox_enable_load: assert property (parameter_write_cmd && param_offset == scp_pkg::OFS_CHAN_LIST
      |=> {cfg.prox_three_enable, cfg.prox_two_enable, cfg.prox_one_enable} == $past(param_wdata[2:0]))
    else $error("Proximity enables do not follow list bits.");
  chk_led_three_mask: assert property (parameter_write_cmd && param_offset == scp_pkg::OFS_LED_THREE
      |=> cfg.prox_three_driver_mask == $past(param_wdata[2:0]))
    else $error("Proximity three mask wrong.");
  chk_prox_align_load: assert property (parameter_write_cmd && param_offset == scp_pkg::OFS_PROX_ALIGN
      |=> {cfg.prox_three_low_align, cfg.prox_two_low_align, cfg.prox_one_low_align} == $past(param_wdata[6:4]))
    else $error("Proximity alignment does not follow write.");
  chk_amb_align_load: assert property (parameter_write_cmd && param_offset == scp_pkg::OFS_AMB_ALIGN
      |=> {cfg.ambient_infrared_low_align, cfg.ambient_visible_low_align} == $past(param_wdata[5:4]))
    else $error("Ambient alignment does not follow write.");
  chk_list_rsvd_zero: assert property (channel_enable_list_q[7] == 1'b0 && channel_enable_list_q[3] == 1'b0)
    else $error("Reserved channel list bits set.");
  chk_led_rsvd_zero: assert property (led_select_prox_one_two_q[7] == 1'b0 && led_select_prox_one_two_q[3] == 1'b0)
    else $error("Reserved first select bits set.");
  chk_align_rsvd_zero: assert property (prox_result_alignment_q[7] == 1'b0 && prox_result_alignment_q[3:0] == 4'h0
      && ambient_result_alignment_q[7:6] == 2'h0 && ambient_result_alignment_q[3:0] == 4'h0)
    else $error("Reserved alignment bits set.");

endmodule // scp_param_bank

// >>> verif/scp_host_model.sv
/*
  Host side model: issues parameter write, read and address-apply commands to the bank.
  Assumes the bank samples commands on the rising clock edge and answers a read one cycle later.
*/
`timescale 1ns/1ps
module scp_host_model #(
  parameter int DRIVER_COUNT = 3
) (
  // Clock
  input  wire logic       clock,
  // Commands
  output logic            parameter_write_cmd,
  output logic            parameter_read_cmd,
  output logic            apply_bus_address_cmd,
  output logic      [7:0] param_offset,
  output logic      [7:0] param_wdata,
  // Answers
  input  wire logic [7:0] param_rdata,
  input  wire logic       param_rvalid
);
  initial begin
    parameter_write_cmd = 1'b0;
    parameter_read_cmd = 1'b0;
    apply_bus_address_cmd = 1'b0;
    param_offset = 8'h00;
    param_wdata = 8'h00;
  end

  // A part with fewer drivers must never see mask bits for drivers it lacks.
  function automatic logic [7:0] legal(input logic [7:0] o, input logic [7:0] d);
    logic [7:0] keep;
    keep = 8'hff;
    if (DRIVER_COUNT < 3) keep = keep & 8'hbb;
    if (DRIVER_COUNT < 2) keep = keep & 8'hdd;
    return (o == 8'h02 || o == 8'h03) ? (d & keep) : d;
  endfunction

  // The channel list is only ever set through this command before any measurement start.
  task automatic write_param(input logic [7:0] o, input logic [7:0] d);
    @(posedge clock);
    #1;
    param_offset = o;
    param_wdata = legal(o, d);
    parameter_write_cmd = 1'b1;
    @(posedge clock);
    #1;
    parameter_write_cmd = 1'b0;
  endtask

  task automatic read_param(input logic [7:0] o, output logic [7:0] d, output logic v, output logic late);
    @(posedge clock);
    #1;
    param_offset = o;
    parameter_read_cmd = 1'b1;
    @(posedge clock);
    #1;
    parameter_read_cmd = 1'b0;
    d = param_rdata;
    v = param_rvalid;
    @(posedge clock);
    #1;
    late = param_rvalid;
  endtask

  task automatic apply_address();
    @(posedge clock);
    #1;
    apply_bus_address_cmd = 1'b1;
    @(posedge clock);
    #1;
    apply_bus_address_cmd = 1'b0;
  endtask
endmodule // scp_host_model

// >>> verif/scp_param_bank_bench.sv
/*
  Self-checking bench for the parameter bank: reset values, field decode, reserved bits, address apply.
  Assumes the host model drives all commands one nanosecond after the rising clock edge.
*/
`timescale 1ns/1ps
module scp_param_bank_bench;
  logic              clock;
  logic              resetn;
  logic              wr_cmd, rd_cmd, ap_cmd, rvalid;
  logic [7:0]        ofs, wdata, rdata, active;
  scp_pkg::scp_cfg_t cfg;
  int                fail_count = 0;
  int                checks = 0;
  logic [7:0]        shadow [0:255];
  logic [7:0]        mask_of [0:255];
  localparam logic [7:0] OFSL [6] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h05, 8'h06};
  localparam logic [7:0] RSTL [6] = '{scp_pkg::RST_BUS_ADDR, 8'h00, 8'h21, 8'h04, 8'h00, 8'h00};
  localparam logic [7:0] MSKL [6] = '{8'hff, 8'h77, 8'h77, 8'h07, 8'h70, 8'h30};

  scp_param_bank dut_u (.clock(clock), .resetn(resetn), .parameter_write_cmd(wr_cmd), .parameter_read_cmd(rd_cmd),
    .apply_bus_address_cmd(ap_cmd), .param_offset(ofs), .param_wdata(wdata), .param_rdata(rdata),
    .param_rvalid(rvalid), .active_bus_address(active), .cfg(cfg));
  scp_host_model host_u (.clock(clock), .parameter_write_cmd(wr_cmd), .parameter_read_cmd(rd_cmd),
    .apply_bus_address_cmd(ap_cmd), .param_offset(ofs), .param_wdata(wdata), .param_rdata(rdata),
    .param_rvalid(rvalid));

  // ==========================================================================
  // Comparison and helpers
  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmpcfg(input scp_pkg::scp_cfg_t got, input scp_pkg::scp_cfg_t exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  function automatic scp_pkg::scp_cfg_t exp_cfg();
    return {shadow[1][6], shadow[1][5], shadow[1][4], shadow[1][2], shadow[1][1], shadow[1][0],
            shadow[2][2:0], shadow[2][6:4], shadow[3][2:0],
            shadow[5][4], shadow[5][5], shadow[5][6], shadow[6][4], shadow[6][5]};
  endfunction
  task automatic reset_shadow();
    for (int i = 0; i < 256; i++) begin
      shadow[i] = 8'h00;
      mask_of[i] = 8'h00;
    end
    for (int i = 0; i < 6; i++) begin
      shadow[OFSL[i]] = RSTL[i];
      mask_of[OFSL[i]] = MSKL[i];
    end
  endtask
  task automatic wr(input logic [7:0] o, input logic [7:0] d);
    host_u.write_param(o, d);
    shadow[o] = host_u.legal(o, d) & mask_of[o];
    cmpcfg(cfg, exp_cfg());
  endtask
  task automatic rd_chk(input logic [7:0] o);
    logic [7:0] d;
    logic       v, late;
    host_u.read_param(o, d, v, late);
    cmp8(d, shadow[o]);
    cmp8({7'h00, v}, 8'h01);
    cmp8({7'h00, late}, 8'h00);
  endtask
  task automatic check_all();
    for (int i = 0; i < 6; i++) rd_chk(OFSL[i]);
    cmpcfg(cfg, exp_cfg());
    cmp8(active, 8'h00);
  endtask
  task automatic conclude();
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ==========================================================================
  // Clock, watchdog and test sequence
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  // The tests need under a thousand cycles; five thousand leaves room without hiding a hang.
  initial begin
    #(5000 * 40);
    fail_count++;
    conclude();
  end
  initial begin
    resetn = 1'b0;
    reset_shadow();
    repeat (20) @(posedge clock);
    #1;
    resetn = 1'b1;
    check_all();
    $display("test reset values done");
    for (int i = 0; i < 6; i++) begin
      for (int b = 0; b < 8; b++) begin
        wr(OFSL[i], 8'h01 << b);
        rd_chk(OFSL[i]);
      end
      wr(OFSL[i], 8'hff);
    end
    for (int i = 0; i < 6; i++) rd_chk(OFSL[i]);
    $display("test field decode done");
    wr(8'h04, 8'hff);
    wr(8'h07, 8'hff);
    rd_chk(8'h04);
    rd_chk(8'h07);
    $display("test unmapped offsets done");
    wr(8'h00, 8'h5a);
    cmp8(active, 8'h00);
    host_u.apply_address();
    cmp8(active, 8'h5a);
    wr(8'h00, 8'ha5);
    cmp8(active, 8'h5a);
    host_u.apply_address();
    cmp8(active, 8'ha5);
    $display("test bus address done");
    @(posedge clock);
    #1;
    resetn = 1'b0;
    reset_shadow();
    repeat (2) @(posedge clock);
    #1;
    resetn = 1'b1;
    check_all();
    $display("test second reset done");
    conclude();
  end
endmodule // scp_param_bank_bench
